// ==== verilog/dfc_pkg.sv ====
// dfc_pkg: object indices, subindices, field layouts and presets for the drive flags bank
// assumes an object-dictionary access port (index + subindex) from the fieldbus stack
package dfc_pkg;
  localparam logic [15:0] DFC_IDX_DRIVE_FLAGS = 16'h3212;
  localparam logic [15:0] DFC_IDX_ANALOG_READ = 16'h3220;
  localparam logic [15:0] DFC_IDX_ANALOG_SEL = 16'h3221;
  localparam logic [15:0] DFC_IDX_PIN_CONFIG = 16'h3231;
  localparam logic [7:0] DFC_SUB_COUNT = 8'h00;
  localparam logic [7:0] DFC_SUB_ONE = 8'h01;
  localparam logic [7:0] DFC_SUB_TWO = 8'h02;
  localparam logic [7:0] DFC_SUB_THREE = 8'h03;
  localparam logic [7:0] DFC_FLAGS_COUNT = 8'h03;
  localparam logic [7:0] DFC_ANALOG_COUNT = 8'h02;
  localparam logic [7:0] DFC_PIN_COUNT = 8'h02;
  localparam logic [7:0] DFC_FLAG_RESET = 8'h00;
  localparam logic [15:0] DFC_READING_RESET = 16'h0000;
  localparam logic [1:0] DFC_SEL_RESET = 2'h0;
  localparam logic [3:0] DFC_MASK_RESET = 4'h0;
  localparam logic [7:0] DFC_DIR_POS = 8'h01;
  localparam logic [7:0] DFC_DIR_NEG = 8'hFF;
  localparam int DFC_NUM_PINS = 4;
  localparam int DFC_PWM_BITS = 8;
  localparam logic [7:0] DFC_PWM_HALF = 8'h80;
  localparam logic [31:0] DFC_ZERO_WORD = 32'h00000000;

  // direction that the field logic is told to use
  typedef enum logic [2:0]
  {
    DFC_DIR_DEFAULT = 3'b001,
    DFC_DIR_FORCE_POS = 3'b010,
    DFC_DIR_FORCE_NEG = 3'b100
  } dfc_dir_type;

  // one object-dictionary request
  typedef struct packed
  {
    logic [15:0] index;
    logic [7:0] sub;
    logic wr;
    logic [31:0] wdata;
  } dfc_req_type;

  // per-pin pad control
  typedef struct packed
  {
    logic [3:0] out_en;
    logic [3:0] pull_en;
    logic [3:0] pull_up;
  } dfc_pad_type;
endpackage

// ==== verilog/dfc_drive_flags.sv ====
// dfc_drive_flags: drive flags, analog readings, analog select and flex pin config objects
// assumes a synchronous object-access strobe from the fieldbus stack on i_mclk, raw
// converter samples on the same clock, and a controller restart pulse from the system
//
// Summary of operation
// RULE1: legacy flag 0 in switched-on state: PWM fixed at half duty, no torque.
// RULE2: legacy flag 1 in switched-on state: PWM follows controller, holding torque.
// RULE3: direction override decoded signed: 0 default, 1 positive, -1 negative.
// RULE4: new direction override acts only after restart; operator reruns auto setup.
// RULE5: keep-gains flag 0: auto setup detects motor type, loads preset gains.
// RULE6: keep-gains flag 1: auto setup uses stored gains, leaves them untouched.
// RULE7: drive-flags entry count reads 03h, read only.
// RULE8: two analog readings are read-only signed 16-bit raw values, reset zero.
// RULE9: software scales current readings by 20 mA per 1024 units.
// RULE10: select bit clear measures voltage, set measures current.
// RULE11: select bit 0 is input one, bit 1 input two, rest no function.
// RULE12: four flex pins map to bits 0 to 3 of each 16-bit mask.
// RULE13: direction bit clear makes pin input (default), set makes output.
// RULE14: pull bit clear gives pull-down (default), set gives pull-up.
// RULE15: pull setting applies only while pin is an input.
// RULE16: written override stays pending, sampled into active logic at restart.
// RULE17: unused select bits and upper mask bits read zero, ignore writes.
`timescale 1ns/1ps

module dfc_drive_flags
  import dfc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_acc_valid,
  input wire dfc_req_type i_acc_req,
  output logic [31:0] o_acc_rdata,
  output logic o_acc_ack,
  output logic o_acc_error,
  input wire logic i_ctrl_restart,
  input wire logic i_switched_on,
  input wire logic [DFC_PWM_BITS-1:0] i_ctrl_pwm,
  output logic [DFC_PWM_BITS-1:0] o_motor_pwm,
  output logic o_holding_torque,
  output dfc_dir_type o_field_dir,
  output logic o_setup_detect_motor,
  output logic o_setup_keep_gains,
  input wire logic i_sample_valid,
  input wire logic [15:0] i_sample_one,
  input wire logic [15:0] i_sample_two,
  output logic o_input_one_current_sel,
  output logic o_input_two_current_sel,
  output dfc_pad_type o_pad_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] holding_power_select_reg;
  logic [7:0] field_direction_override_reg;
  logic [7:0] keep_gain_settings_reg;
  logic [7:0] active_direction_reg;
  logic [15:0] analog_reading_one_reg;
  logic [15:0] analog_reading_two_reg;
  logic [1:0] analog_measure_select_reg;
  logic [3:0] pin_direction_mask_reg;
  logic [3:0] pin_pull_mask_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic err_reg;
  logic [DFC_PWM_BITS-1:0] pwm_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic hit_flags = i_acc_req.index == DFC_IDX_DRIVE_FLAGS;
  wire logic hit_read = i_acc_req.index == DFC_IDX_ANALOG_READ;
  wire logic hit_sel = i_acc_req.index == DFC_IDX_ANALOG_SEL;
  wire logic hit_pin = i_acc_req.index == DFC_IDX_PIN_CONFIG;
  wire logic sub0 = i_acc_req.sub == DFC_SUB_COUNT;
  wire logic sub1 = i_acc_req.sub == DFC_SUB_ONE;
  wire logic sub2 = i_acc_req.sub == DFC_SUB_TWO;
  wire logic sub3 = i_acc_req.sub == DFC_SUB_THREE;
  wire logic do_wr = i_acc_valid && i_acc_req.wr;
  wire logic wr_power = do_wr && hit_flags && sub1;
  wire logic wr_dir = do_wr && hit_flags && sub2;
  wire logic wr_keep = do_wr && hit_flags && sub3;
  wire logic wr_sel = do_wr && hit_sel && sub0;
  wire logic wr_dmask = do_wr && hit_pin && sub1;
  wire logic wr_pmask = do_wr && hit_pin && sub2;
  // known object/subindex pairs; writable ones are a subset
  wire logic known = (hit_flags && (sub0 || sub1 || sub2 || sub3))
    || (hit_read && (sub0 || sub1 || sub2)) || (hit_sel && sub0)
    || (hit_pin && (sub0 || sub1 || sub2));
  wire logic writable = wr_power || wr_dir || wr_keep || wr_sel || wr_dmask || wr_pmask;
  wire logic refused = i_acc_valid && (!known || (i_acc_req.wr && !writable));

  ////////////////////////////////////////////////////////////////////////////
  // read mux; narrow objects sit in low bits, signed ones sign-extended
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = DFC_ZERO_WORD;
    if (hit_flags && sub0)
      rd_mux = {24'h000000, DFC_FLAGS_COUNT}; // see RULE7
    else if (hit_flags && sub1)
      rd_mux = {{24{holding_power_select_reg[7]}}, holding_power_select_reg};
    else if (hit_flags && sub2)
      rd_mux = {{24{field_direction_override_reg[7]}}, field_direction_override_reg};
    else if (hit_flags && sub3)
      rd_mux = {{24{keep_gain_settings_reg[7]}}, keep_gain_settings_reg};
    else if (hit_read && sub0)
      rd_mux = {24'h000000, DFC_ANALOG_COUNT};
    else if (hit_read && sub1)
      rd_mux = {{16{analog_reading_one_reg[15]}}, analog_reading_one_reg}; // see RULE8
    else if (hit_read && sub2)
      rd_mux = {{16{analog_reading_two_reg[15]}}, analog_reading_two_reg}; // see RULE8
    else if (hit_sel && sub0)
      rd_mux = {30'h0, analog_measure_select_reg}; // see RULE17
    else if (hit_pin && sub0)
      rd_mux = {24'h000000, DFC_PIN_COUNT};
    else if (hit_pin && sub1)
      rd_mux = {28'h0000000, pin_direction_mask_reg}; // see RULE17
    else if (hit_pin && sub2)
      rd_mux = {28'h0000000, pin_pull_mask_reg}; // see RULE17
  end

  // answer one cycle after the request
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rdata_reg <= DFC_ZERO_WORD;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= i_acc_valid;
      err_reg <= refused;
      if (i_acc_valid)
        rdata_reg <= refused ? DFC_ZERO_WORD : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable flags and masks; only defined bits are kept
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      holding_power_select_reg <= DFC_FLAG_RESET;
      field_direction_override_reg <= DFC_FLAG_RESET;
      keep_gain_settings_reg <= DFC_FLAG_RESET;
      analog_measure_select_reg <= DFC_SEL_RESET;
      pin_direction_mask_reg <= DFC_MASK_RESET;
      pin_pull_mask_reg <= DFC_MASK_RESET;
    end
    else
    begin
      if (wr_power)
        holding_power_select_reg <= i_acc_req.wdata[7:0];
      if (wr_dir)
        field_direction_override_reg <= i_acc_req.wdata[7:0]; // see RULE16
      if (wr_keep)
        keep_gain_settings_reg <= i_acc_req.wdata[7:0];
      if (wr_sel)
        analog_measure_select_reg <= i_acc_req.wdata[1:0]; // see RULE11, see RULE17
      if (wr_dmask)
        pin_direction_mask_reg <= i_acc_req.wdata[DFC_NUM_PINS-1:0]; // see RULE12
      if (wr_pmask)
        pin_pull_mask_reg <= i_acc_req.wdata[DFC_NUM_PINS-1:0]; // see RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending override copied to the active direction only on restart, so a
  // mid-run write cannot flip the field under a turning motor
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      active_direction_reg <= DFC_FLAG_RESET;
    else if (i_ctrl_restart)
      active_direction_reg <= field_direction_override_reg; // see RULE4, see RULE16
  end

  // signed decode; other values fall back to the firmware default
  always_comb
  begin
    case (active_direction_reg)
      DFC_DIR_POS: o_field_dir = DFC_DIR_FORCE_POS; // see RULE3
      DFC_DIR_NEG: o_field_dir = DFC_DIR_FORCE_NEG; // see RULE3
      default: o_field_dir = DFC_DIR_DEFAULT; // see RULE3
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // motor PWM selection in the switched-on state
  wire logic legacy_on = holding_power_select_reg == DFC_DIR_POS;
  wire logic pwm_half = i_switched_on && !legacy_on;
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pwm_reg <= DFC_PWM_HALF;
    else
      pwm_reg <= pwm_half ? DFC_PWM_HALF : i_ctrl_pwm; // see RULE1, see RULE2
  end
  assign o_motor_pwm = pwm_reg;
  assign o_holding_torque = i_switched_on && legacy_on; // see RULE2

  ////////////////////////////////////////////////////////////////////////////
  // auto setup policy
  wire logic keep_on = keep_gain_settings_reg == DFC_DIR_POS;
  assign o_setup_keep_gains = keep_on; // see RULE6
  assign o_setup_detect_motor = !keep_on; // see RULE5

  ////////////////////////////////////////////////////////////////////////////
  // raw converter samples latched as they arrive
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      analog_reading_one_reg <= DFC_READING_RESET;
      analog_reading_two_reg <= DFC_READING_RESET;
    end
    else if (i_sample_valid)
    begin
      analog_reading_one_reg <= i_sample_one; // see RULE8
      analog_reading_two_reg <= i_sample_two;
    end
  end

  // 1 = current, 0 = voltage
  assign o_input_one_current_sel = analog_measure_select_reg[0]; // see RULE10
  assign o_input_two_current_sel = analog_measure_select_reg[1]; // see RULE10

  ////////////////////////////////////////////////////////////////////////////
  // pad control per pin; pull only enabled for inputs
  generate
    for (genvar p = 0; p < DFC_NUM_PINS; p++)
    begin : g_pin
      assign o_pad_ctrl.out_en[p] = pin_direction_mask_reg[p]; // see RULE13
      assign o_pad_ctrl.pull_en[p] = !pin_direction_mask_reg[p]; // see RULE15
      assign o_pad_ctrl.pull_up[p] = !pin_direction_mask_reg[p] && pin_pull_mask_reg[p]; // see RULE14
    end
  endgenerate

  assign o_acc_rdata = rdata_reg;
  assign o_acc_ack = ack_reg;
  assign o_acc_error = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  // a write of the override that no restart meets in the same cycle
  sequence s_dir_write;
    wr_dir && !i_ctrl_restart;
  endsequence

  // the following cycle, still without a restart
  sequence s_no_restart;
    !i_ctrl_restart;
  endsequence

  // a read of either converter reading
  sequence s_read_reading;
    i_acc_valid && !i_acc_req.wr && hit_read && (sub1 || sub2);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // motor power and holding torque; the reset term keeps the release edge, at which
  // pwm_reg is still held in reset, from starting an attempt
  a_half_duty_hold: assert property (pwm_half |=> o_motor_pwm == DFC_PWM_HALF) // see RULE1
    else $error("pwm not half in switched-on without legacy flag");
  a_ctrl_pwm_pass: assert property (i_rst_b && !pwm_half // see RULE2
    |=> o_motor_pwm == $past(i_ctrl_pwm))
    else $error("pwm does not follow controller");
  a_torque_off: assert property (i_switched_on // see RULE1
    && holding_power_select_reg == DFC_FLAG_RESET |-> !o_holding_torque)
    else $error("holding torque with legacy flag clear");
  a_torque_on: assert property (i_switched_on // see RULE2
    && holding_power_select_reg == DFC_DIR_POS |-> o_holding_torque)
    else $error("no holding torque with legacy flag set");

  ////////////////////////////////////////////////////////////////////////////
  // field direction decode and restart gating
  a_dir_decode: assert property (active_direction_reg == DFC_DIR_NEG // see RULE3
    |-> o_field_dir == DFC_DIR_FORCE_NEG)
    else $error("negative override not decoded");
  a_dir_positive: assert property (active_direction_reg == DFC_DIR_POS // see RULE3
    |-> o_field_dir == DFC_DIR_FORCE_POS)
    else $error("positive override not decoded");
  a_dir_default: assert property (active_direction_reg == DFC_FLAG_RESET // see RULE3
    |-> o_field_dir == DFC_DIR_DEFAULT)
    else $error("zero override not decoded as default");
  // judged one edge late so that a write leaking straight through would show
  a_dir_pending: assert property (s_dir_write ##1 s_no_restart // see RULE16
    |=> $stable(active_direction_reg))
    else $error("override took effect without restart");
  a_dir_restart: assert property (i_ctrl_restart // see RULE4
    |=> active_direction_reg == $past(field_direction_override_reg))
    else $error("restart did not load override");

  ////////////////////////////////////////////////////////////////////////////
  // object access answers and read-only entries
  a_count_read: assert property (i_acc_valid && !i_acc_req.wr && hit_flags && sub0 // see RULE7
    |=> o_acc_rdata == {24'h000000, DFC_FLAGS_COUNT} && o_acc_ack)
    else $error("entry count wrong");
  a_count_kept: assert property (i_acc_valid && i_acc_req.wr && hit_flags && sub0 // see RULE7
    |=> o_acc_ack && o_acc_error && o_acc_rdata == DFC_ZERO_WORD)
    else $error("write to entry count not refused");
  a_reading_latch: assert property (i_sample_valid // see RULE8
    |=> analog_reading_one_reg == $past(i_sample_one)
    && analog_reading_two_reg == $past(i_sample_two))
    else $error("converter sample not latched");
  a_reading_fixed: assert property (i_acc_valid && i_acc_req.wr && hit_read // see RULE8
    && !i_sample_valid |=> $stable(analog_reading_one_reg) && $stable(analog_reading_two_reg))
    else $error("read-only reading changed by a write");
  a_reading_sign: assert property (s_read_reading // see RULE8
    |=> o_acc_rdata[31:16] == {16{o_acc_rdata[15]}})
    else $error("reading not sign-extended");

  ////////////////////////////////////////////////////////////////////////////
  // measure select
  a_sel_mask: assert property (wr_sel // see RULE11
    |=> analog_measure_select_reg == $past(i_acc_req.wdata[1:0]))
    else $error("select word not stored");
  a_sel_outputs: assert property (wr_sel // see RULE10
    |=> o_input_one_current_sel == $past(i_acc_req.wdata[0])
    && o_input_two_current_sel == $past(i_acc_req.wdata[1]))
    else $error("measure select not on outputs");
  a_sel_upper: assert property (i_acc_valid && !i_acc_req.wr && hit_sel && sub0 // see RULE17
    |=> o_acc_rdata[31:2] == 30'h0)
    else $error("undefined select bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // flex pins
  a_pull_gate: assert property (pin_direction_mask_reg[0] // see RULE15
    |-> !o_pad_ctrl.pull_en[0] && !o_pad_ctrl.pull_up[0])
    else $error("pull active on output pin");
  a_dir_mask: assert property (wr_dmask // see RULE13
    |=> o_pad_ctrl.out_en == $past(i_acc_req.wdata[DFC_NUM_PINS-1:0]))
    else $error("direction mask not on pads");
  a_pull_mask: assert property (wr_pmask // see RULE14
    |=> o_pad_ctrl.pull_up == ($past(i_acc_req.wdata[DFC_NUM_PINS-1:0]) & ~o_pad_ctrl.out_en))
    else $error("pull mask not on input pads");
  a_mask_upper: assert property (i_acc_valid && !i_acc_req.wr && hit_pin // see RULE17
    && (sub1 || sub2) |=> o_acc_rdata[31:4] == 28'h0)
    else $error("upper mask bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // auto setup policy
  a_keep_gain: assert property (wr_keep && i_acc_req.wdata[7:0] == DFC_DIR_POS // see RULE6
    |=> o_setup_keep_gains && !o_setup_detect_motor)
    else $error("keep gains policy wrong");
  a_detect_motor: assert property (keep_gain_settings_reg == DFC_FLAG_RESET // see RULE5
    |-> o_setup_detect_motor && !o_setup_keep_gains)
    else $error("motor detection not chosen with flag clear");
endmodule

// ==== sim/dfc_partner_model.sv ====
// dfc_partner_model: controller pwm source and analog converter beside the flags bank
// assumes the bench pulses i_take for one fresh converter sample pair
`timescale 1ns/1ps

module dfc_partner_model
(
  input wire logic i_mclk,
  input wire logic i_take,
  input wire logic i_current_sel,
  output logic [7:0] o_ctrl_pwm,
  output logic o_sample_valid,
  output logic [15:0] o_sample_one,
  output logic [15:0] o_sample_two,
  output logic [15:0] o_input_one_ma
);
  ////////////////////////////////////////////////////////////
  // pwm moves every cycle, so a stale or frozen copy shows up
  initial
  begin
    o_ctrl_pwm = 8'h00;
    o_sample_valid = 1'b0;
    o_sample_one = 16'h0000;
    o_sample_two = 16'h0000;
  end
  always @(posedge i_mclk)
  begin
    o_ctrl_pwm <= 8'($urandom);
    o_sample_valid <= i_take;
    if (i_take)
    begin
      o_sample_one <= 16'($urandom);
      o_sample_two <= 16'($urandom);
    end
  end
  // host-side scaling of a current reading; voltage left raw
  assign o_input_one_ma = i_current_sel ?
    16'((32'($signed(o_sample_one)) * 20) / 1024) : o_sample_one;
endmodule

// ==== sim/drive_flags_and_io_config_tb_top.sv ====
// drive_flags_and_io_config_tb_top: self-checking bench for the drive flags bank
// assumes dfc_pkg compiled first and the partner model beside the design
`timescale 1ns/1ps

module drive_flags_and_io_config_tb_top;
  import dfc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic acc_valid = 1'b0;
  dfc_req_type acc_req = '0;
  logic restart = 1'b0;
  logic sw_on = 1'b0;
  logic take = 1'b0;
  logic [31:0] rdata, rdv, v, w;
  logic ack, err, torque, detect, keep, sel1, sel2, svalid, erv, cur;
  logic [7:0] ctrl_pwm, motor_pwm, pw, f;
  logic [15:0] s1, s2, ma1;
  dfc_dir_type fdir, dold;
  dfc_pad_type pad;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // index, sub, preset
  localparam logic [31:0] PRESET [11] = '{32'h32120003, 32'h32120100, 32'h32120200,
    32'h32120300, 32'h32200002, 32'h32200100, 32'h32200200, 32'h32210000, 32'h32310002,
    32'h32310100, 32'h32310200};
  // read-only entries and unmapped pairs
  localparam logic [23:0] REFUSE [7] = '{24'h321200, 24'h322000, 24'h322001, 24'h323100,
    24'h321300, 24'h321204, 24'h322101};
  localparam logic [7:0] DIRV [5] = '{8'h01, 8'hFF, 8'h00, 8'h05, 8'hFF};

  dfc_drive_flags dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_acc_valid(acc_valid),
    .i_acc_req(acc_req), .o_acc_rdata(rdata), .o_acc_ack(ack), .o_acc_error(err),
    .i_ctrl_restart(restart), .i_switched_on(sw_on), .i_ctrl_pwm(ctrl_pwm),
    .o_motor_pwm(motor_pwm), .o_holding_torque(torque), .o_field_dir(fdir),
    .o_setup_detect_motor(detect), .o_setup_keep_gains(keep), .i_sample_valid(svalid),
    .i_sample_one(s1), .i_sample_two(s2), .o_input_one_current_sel(sel1),
    .o_input_two_current_sel(sel2), .o_pad_ctrl(pad));
  dfc_partner_model partner (.i_mclk(mclk), .i_take(take), .i_current_sel(sel1),
    .o_ctrl_pwm(ctrl_pwm), .o_sample_valid(svalid), .o_sample_one(s1),
    .o_sample_two(s2), .o_input_one_ma(ma1));

  ////////////////////////////////////////////////////////////
  // 125 MHz clock and a hang limit well above the run length
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////
  // expectations and bus helpers
  function automatic logic [31:0] sx8(logic [7:0] b);
    return {{24{b[7]}}, b};
  endfunction
  function automatic dfc_dir_type dexp(logic [7:0] d);
    return (d == 8'h01) ? DFC_DIR_FORCE_POS : (d == 8'hFF) ? DFC_DIR_FORCE_NEG : DFC_DIR_DEFAULT;
  endfunction
  function automatic dfc_pad_type pexp(logic [3:0] dir, logic [3:0] pull);
    return '{dir, ~dir, ~dir & pull};
  endfunction
  // host scaling of a reading: current mode in mA, voltage mode raw
  function automatic logic [15:0] maexp(logic [31:0] raw, logic c);
    return c ? 16'(($signed(raw) * 20) / 1024) : raw[15:0];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, held a single edge; answer read after ack lands
  task automatic xfer(input logic [15:0] i, input logic [7:0] s, input logic wr,
    input logic [31:0] d);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_req <= '{index: i, sub: s, wr: wr, wdata: d};
    @(posedge mclk);
    acc_valid <= 1'b0;
    #1;
    chk(32'(ack), 32'h1);
    rdv = rdata;
    erv = err;
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(54));
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk(32'(fdir), 32'(DFC_DIR_DEFAULT));
    chk(32'(pad), 32'(pexp(4'h0, 4'h0)));
    foreach (PRESET[i])
    begin
      xfer(PRESET[i][31:16], PRESET[i][15:8], 1'b0, 32'h0);
      chk({erv, rdv[30:0]}, {24'h0, PRESET[i][7:0]});
    end
    // refused writes answer with error and zero data; only the drive-flags count is read back after
    foreach (REFUSE[i])
    begin
      xfer(REFUSE[i][23:8], REFUSE[i][7:0], 1'b1, 32'h5A);
      chk({erv, rdv[30:0]}, 32'h80000000);
    end
    xfer(16'h3212, 8'h00, 1'b0, 32'h0);
    chk(rdv, 32'h03);
    // pin masks, all-ones corner first, then random
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'hFFFFFFFF : $urandom;
      w = (i == 0) ? 32'h0000000F : $urandom;
      xfer(16'h3231, 8'h01, 1'b1, v);
      xfer(16'h3231, 8'h02, 1'b1, w);
      chk(32'(pad), 32'(pexp(v[3:0], w[3:0])));
      xfer(16'h3231, 8'h01, 1'b0, 32'h0);
      chk(rdv, {28'h0, v[3:0]});
      xfer(16'h3231, 8'h02, 1'b0, 32'h0);
      chk(rdv, {28'h0, w[3:0]});
    end
    // analog measure select
    repeat (4)
    begin
      v = $urandom;
      xfer(16'h3221, 8'h00, 1'b1, v);
      chk({30'h0, sel2, sel1}, {30'h0, v[1:0]});
      xfer(16'h3221, 8'h00, 1'b0, 32'h0);
      chk(rdv, {30'h0, v[1:0]});
    end
    // keep-gains flag, exactly one keeps the stored gains
    foreach (DIRV[i])
    begin
      xfer(16'h3212, 8'h03, 1'b1, {24'h0, DIRV[i]});
      chk({30'h0, detect, keep}, (DIRV[i] == 8'h01) ? 32'h1 : 32'h2);
    end
    // switched-on power: off, legacy 0, legacy 1, legacy -1
    for (int k = 0; k < 4; k++)
    begin
      f = (k == 2) ? 8'h01 : (k == 3) ? 8'hFF : 8'h00;
      @(posedge mclk);
      sw_on <= (k != 0);
      xfer(16'h3212, 8'h01, 1'b1, {24'h0, f});
      repeat (3)
      begin
        @(posedge mclk);
        #1;
        pw = ctrl_pwm;
        @(posedge mclk);
        #1;
        chk(32'(motor_pwm), (k == 1 || k == 3) ? 32'h80 : 32'(pw));
        chk(32'(torque), (k == 2) ? 32'h1 : 32'h0);
      end
    end
    // direction override waits for restart
    dold = DFC_DIR_DEFAULT;
    foreach (DIRV[i])
    begin
      xfer(16'h3212, 8'h02, 1'b1, {24'h0, DIRV[i]});
      xfer(16'h3212, 8'h02, 1'b0, 32'h0);
      chk(rdv, sx8(DIRV[i]));
      chk(32'(fdir), 32'(dold));
      @(posedge mclk);
      restart <= 1'b1;
      @(posedge mclk);
      restart <= 1'b0;
      #1;
      dold = dexp(DIRV[i]);
      chk(32'(fdir), 32'(dold));
    end
    // converter readings, negative ones sign-extended; current mode toggled each pass
    cur = 1'b0;
    repeat (6)
    begin
      cur = !cur;
      xfer(16'h3221, 8'h00, 1'b1, {31'h0, cur});
      @(posedge mclk);
      take <= 1'b1;
      @(posedge mclk);
      take <= 1'b0;
      xfer(16'h3220, 8'h01, 1'b0, 32'h0);
      chk(rdv, {{16{s1[15]}}, s1});
      chk(32'(ma1), 32'(maexp(rdv, cur)));
      xfer(16'h3220, 8'h02, 1'b0, 32'h0);
      chk(rdv, {{16{s2[15]}}, s2});
    end
    close_out();
  end
endmodule
